/* dual_config_logic_cells.sv */
/*
 * Two configurable logic cells with cascade, behind a byte register port.
 * Assumes synchronous pins and a master that never issues read and write together.
 */
// Our own choice: the strobed register port.
// Function
// - Cell one selector picks its function
// - Cell two uses same function encoding
// - Cell one bits 3-5 invert inputs
// - Cell one bit 6 inverts output
// - Cell two bits 3-5 invert inputs
// - Cell two bit 6 inverts output
// - Cell two bit 7 chains cell one
// - Chained input pin stays free for reuse
// - Cell one flop force set/clear bits
// - Cell two flop force set/clear bits
`timescale 1ns/10ps
module dual_config_logic_cells (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       cell_one_input_a,
	input  wire logic       cell_one_input_b,
	input  wire logic       cell_one_input_c,
	input  wire logic       cell_two_input_a,
	input  wire logic       cell_two_input_b,
	input  wire logic       cell_two_input_c,
	output logic            cell_one_output,
	output logic            cell_two_output,
	output logic            cell_two_pin_a_free
);

	// ------------------------------------------------------------------
	// Internal nets
	// ------------------------------------------------------------------
	logic [7:0]  cell_one_config_q;
	logic [7:0]  cell_two_config_q;
	logic [3:0]  flop_ctrl_q;
	logic [15:0] cell_cfg;
	logic [5:0]  cell_pin;
	logic [1:0]  cell_set;
	logic [1:0]  cell_clr;
	wire  [1:0]  cell_out;
	wire  [1:0]  cell_flop;
	logic        one_out;
	logic        two_out;
	logic        one_flop;
	logic        two_flop;
	logic        two_a;
	logic        wr_one;
	logic        wr_two;
	logic        wr_flop;
	logic        one_set;
	logic        one_clr;
	logic        two_set;
	logic        two_clr;
	logic        chain_on;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Shared by every write strobe, so one compare rule serves all
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction : addr_hit

	assign wr_one   = reg_wr && addr_hit(reg_addr, cell_pkg::cell_one_config_addr);
	assign wr_two   = reg_wr && addr_hit(reg_addr, cell_pkg::cell_two_config_addr);
	assign wr_flop  = reg_wr && addr_hit(reg_addr, cell_pkg::cell_flop_ctrl_addr);
	assign chain_on = cell_two_config_q[cell_pkg::chain_bit];

	// ------------------------------------------------------------------
	// Write masks
	// ------------------------------------------------------------------
	// Reserved bits are dropped at write time, so they always read zero
	function automatic logic [7:0] write_mask(input logic [7:0] addr);
		case (addr)
			cell_pkg::cell_one_config_addr: return 8'h7f;
			cell_pkg::cell_two_config_addr: return 8'hff;
			cell_pkg::cell_flop_ctrl_addr:  return 8'h0f;
			default:                        return 8'h00;
		endcase
	endfunction : write_mask

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cell_one_config_q <= cell_pkg::config_reset;
		end else if (wr_one) begin
			cell_one_config_q <= reg_wdata & write_mask(cell_pkg::cell_one_config_addr);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cell_two_config_q <= cell_pkg::config_reset;
		end else if (wr_two) begin
			cell_two_config_q <= reg_wdata & write_mask(cell_pkg::cell_two_config_addr);
		end
	end

	// ------------------------------------------------------------------
	// Force strobes
	// ------------------------------------------------------------------
	// Force bits are write-one strobes; stored copy reads back
	// Strobes last only the write cycle, so a held value never re-forces
	assign one_set = wr_flop & reg_wdata[cell_pkg::one_force_high];
	assign one_clr = wr_flop & reg_wdata[cell_pkg::one_force_low];
	assign two_set = wr_flop & reg_wdata[cell_pkg::two_force_high];
	assign two_clr = wr_flop & reg_wdata[cell_pkg::two_force_low];

	// ------------------------------------------------------------------
	// Flop control store
	// ------------------------------------------------------------------
	// Readback of the last force word only; the strobes act once
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flop_ctrl_q <= 4'h0;
		end else if (wr_flop) begin
			flop_ctrl_q <= reg_wdata[3:0];
		end
	end

	// ------------------------------------------------------------------
	// Read port: unmapped addresses read zero
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				cell_pkg::cell_one_config_addr: reg_rdata <= cell_one_config_q;
				cell_pkg::cell_two_config_addr: reg_rdata <= cell_two_config_q;
				cell_pkg::cell_flop_ctrl_addr:  reg_rdata <= {2'h0, two_flop, one_flop,
									flop_ctrl_q};
				default:                        reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Cells
	// ------------------------------------------------------------------
	// Cascade takes the registered cell one output: one cycle of extra lag
	assign two_a = cell_two_config_q[cell_pkg::chain_bit] ? one_out
							      : cell_two_input_a;

	// ------------------------------------------------------------------
	// Cell array
	// ------------------------------------------------------------------
	assign cell_cfg = {cell_two_config_q, cell_one_config_q};
	assign cell_pin = {two_a, cell_two_input_b, cell_two_input_c,
		cell_one_input_a, cell_one_input_b, cell_one_input_c};
	assign cell_set = {two_set, one_set};
	assign cell_clr = {two_clr, one_clr};

	// Both cells share one build, so they cannot drift apart
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cell
			logic_cell u_cell (
				.clk_sys    (clk_sys),
				.rstn       (rstn),
				.cfg        (cell_cfg[g*8 +: 8]),
				.in_a       (cell_pin[g*3+2]),
				.in_b       (cell_pin[g*3+1]),
				.in_c       (cell_pin[g*3]),
				.force_high (cell_set[g]),
				.force_low  (cell_clr[g]),
				.out_q      (cell_out[g]),
				.flop_q     (cell_flop[g])
			);
		end
	endgenerate

	assign one_out  = cell_out[0];
	assign two_out  = cell_out[1];
	assign one_flop = cell_flop[0];
	assign two_flop = cell_flop[1];

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Pins come from flops: glitch free, at the cost of one cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cell_one_output <= 1'b0;
		end else begin
			cell_one_output <= one_out;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cell_two_output <= 1'b0;
		end else begin
			cell_two_output <= two_out;
		end
	end

	// ------------------------------------------------------------------
	// Pin release
	// ------------------------------------------------------------------
	// Follows the chain bit one cycle after the write
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cell_two_pin_a_free <= 1'b0;
		end else begin
			cell_two_pin_a_free <= chain_on;
		end
	end

endmodule : dual_config_logic_cells

/* cell_pkg.sv */
/*
 * Constants shared by the configurable logic cell pair: register offsets,
 * field positions, reset values and function select encodings.
 * Assumes a byte-wide register port with an 8-bit address.
 */
package cell_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] cell_one_config_addr = 8'h44;
	localparam logic [7:0] cell_two_config_addr = 8'h45;
	localparam logic [7:0] cell_flop_ctrl_addr  = 8'h46;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int sel_lsb        = 0;
	localparam int inv_a_bit      = 3;
	localparam int inv_b_bit      = 4;
	localparam int inv_c_bit      = 5;
	localparam int out_inv_bit    = 6;
	localparam int chain_bit      = 7;
	localparam int one_force_low  = 0;
	localparam int one_force_high = 1;
	localparam int two_force_low  = 2;
	localparam int two_force_high = 3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] config_reset = 8'h00;
	localparam logic       flop_reset   = 1'b0;

	// ------------------------------------------------------------------
	// Function encodings
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		fn_off    = 3'b000,
		fn_and    = 3'b001,
		fn_or     = 3'b010,
		fn_xor    = 3'b011,
		fn_flop   = 3'b100,
		fn_pass_a = 3'b101,
		fn_pass_b = 3'b110,
		fn_pass_c = 3'b111
	} cell_fn_t;

endpackage : cell_pkg

/* logic_cell.sv */
/*
 * One configurable three-input logic cell with input and output inversion
 * and an internal flip-flop; output registered.
 * Assumes synchronous inputs and the shared package.
 */
`timescale 1ns/10ps
module logic_cell (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic [7:0] cfg,
	input  wire logic       in_a,
	input  wire logic       in_b,
	input  wire logic       in_c,
	input  wire logic       force_high,
	input  wire logic       force_low,
	output logic            out_q,
	output logic            flop_q
);

	logic       a_d;
	logic       b_d;
	logic       c_d;
	logic       b_prev_q;
	logic       res_d;
	cell_pkg::cell_fn_t fn;

	// ------------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------------
	assign a_d = in_a ^ cfg[cell_pkg::inv_a_bit];
	assign b_d = in_b ^ cfg[cell_pkg::inv_b_bit];
	assign c_d = in_c ^ cfg[cell_pkg::inv_c_bit];
	assign fn  = cell_pkg::cell_fn_t'(cfg[cell_pkg::sel_lsb +: 3]);

	// ------------------------------------------------------------------
	// Flip-flop: data A, rising edge of B; force wins, high over low
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			b_prev_q <= 1'b0;
		end else begin
			b_prev_q <= b_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flop_q <= cell_pkg::flop_reset;
		end else if (force_high) begin
			flop_q <= 1'b1;
		end else if (force_low) begin
			flop_q <= 1'b0;
		end else if (b_d && !b_prev_q) begin
			flop_q <= a_d;
		end
	end

	// ------------------------------------------------------------------
	// Function select
	// ------------------------------------------------------------------
	always_comb begin
		case (fn)
			cell_pkg::fn_off:    res_d = 1'b0;
			cell_pkg::fn_and:    res_d = a_d & b_d & c_d;
			cell_pkg::fn_or:     res_d = a_d | b_d | c_d;
			cell_pkg::fn_xor:    res_d = a_d ^ b_d ^ c_d;
			cell_pkg::fn_flop:   res_d = flop_q;
			cell_pkg::fn_pass_a: res_d = a_d;
			cell_pkg::fn_pass_b: res_d = b_d;
			cell_pkg::fn_pass_c: res_d = c_d;
			default:             res_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_q <= 1'b0;
		end else begin
			out_q <= res_d ^ cfg[cell_pkg::out_inv_bit];
		end
	end

endmodule : logic_cell

/* cell_pins.sv */
/* Pin source model for the logic cell pair, plus a reference cell function.
   Assumes the bench sets the wanted pin levels once per cycle. */
`timescale 1ns/10ps
package cell_ref_pkg;
	function automatic logic exp_cell(logic [7:0] f, logic a, logic b, logic c);
		logic [2:0] v;
		logic       r;
		v = {a, b, c} ^ {f[3], f[4], f[5]};
		case (f[2:0])
			3'h1: r = &v;
			3'h2: r = |v;
			3'h3: r = ^v;
			3'h5: r = v[2];
			3'h6: r = v[1];
			3'h7: r = v[0];
			default: r = 1'b0;
		endcase
		return r ^ f[6];
	endfunction : exp_cell
endpackage : cell_ref_pkg
module cell_pins (
	input  wire logic       clk_sys,
	input  wire logic [5:0] want,
	output logic      [5:0] pins = 6'h00
);
	// Pads move only after an edge, so the block never sees a race
	always @(posedge clk_sys) pins <= want;
endmodule : cell_pins

/* cell_chk_chk.sv */
/* Port checks for the logic cell pair, bound to its top.
   Assumes at most one strobe per cycle. */
`timescale 1ns/10ps
module cell_chk (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       cell_one_input_a,
	input wire logic       cell_one_input_b,
	input wire logic       cell_one_input_c,
	input wire logic       cell_two_input_a,
	input wire logic       cell_two_input_b,
	input wire logic       cell_two_input_c,
	input wire logic       cell_one_output,
	input wire logic       cell_two_output,
	input wire logic       cell_two_pin_a_free
);
	logic [7:0] one_q, two_q;
	logic [5:0] p1_q, p2_q;
	logic [1:0] age_q;
	// Configs mirrored from the bus, since internals are hidden
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{one_q, two_q, p1_q, p2_q, age_q} <= '0;
		end else begin
			p1_q <= {cell_one_input_a, cell_one_input_b, cell_one_input_c,
				cell_two_input_a, cell_two_input_b, cell_two_input_c};
			p2_q <= p1_q;
			age_q <= reg_wr ? 2'h0 : age_q + 2'(age_q != 2'h3);
			if (reg_wr && reg_addr == 8'h44) one_q <= reg_wdata & 8'h7f;
			if (reg_wr && reg_addr == 8'h45) two_q <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_one_func: assert property (age_q == 2'h3 && one_q[2:0] != 3'h4
		|-> cell_one_output == cell_ref_pkg::exp_cell(one_q, p2_q[5], p2_q[4], p2_q[3]))
		else $error("cell one result wrong");
	a_two_func: assert property (age_q == 2'h3 && two_q[2:0] != 3'h4 && !two_q[7]
		|-> cell_two_output == cell_ref_pkg::exp_cell(two_q, p2_q[2], p2_q[1], p2_q[0]))
		else $error("cell two result wrong");
	a_chain_path: assert property (age_q == 2'h3 && two_q[2:0] != 3'h4 && two_q[7]
		|-> cell_two_output == cell_ref_pkg::exp_cell(two_q, $past(cell_one_output), p2_q[1],
		p2_q[0])) else $error("chained result wrong");
	a_pin_free: assert property (age_q == 2'h3 |-> cell_two_pin_a_free == two_q[7])
		else $error("pin release wrong");
	a_read_one: assert property ($past(reg_rd && reg_addr == 8'h44)
		|-> reg_rdata == $past(one_q)) else $error("config one readback wrong");
	a_read_two: assert property ($past(reg_rd && reg_addr == 8'h45)
		|-> reg_rdata == $past(two_q)) else $error("config two readback wrong");
	a_read_none: assert property ($past(reg_rd && (reg_addr < 8'h44 || reg_addr > 8'h46))
		|-> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	c_chain: cover property (age_q == 2'h3 && two_q[7] && cell_two_output);
	c_flop: cover property (one_q[2:0] == 3'h4 && cell_one_output);
	c_none: cover property (reg_rd && reg_addr == 8'h50);
endmodule : cell_chk
bind dual_config_logic_cells cell_chk u_chk (.*);

/* dual_config_logic_cells_tb.sv */
/* Self-checking bench for the logic cell pair.
   Assumes the pin model and the bound checker. */
`timescale 1ns/10ps
module dual_config_logic_cells_tb;
	logic       clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [5:0] want = 6'h00;
	wire  [7:0] reg_rdata;
	wire  [5:0] pins;
	wire  [2:0] ys;
	int         err_total = 0, cmp_count = 0;
	always #12.5 clk_sys = ~clk_sys;
	cell_pins u_pins (.clk_sys(clk_sys), .want(want), .pins(pins));
	dual_config_logic_cells u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cell_one_input_a(pins[5]), .cell_one_input_b(pins[4]), .cell_one_input_c(pins[3]),
		.cell_two_input_a(pins[2]), .cell_two_input_b(pins[1]), .cell_two_input_c(pins[0]),
		.cell_one_output(ys[2]), .cell_two_output(ys[1]), .cell_two_pin_a_free(ys[0]));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_out
	// One strobe then an idle cycle, so no signal is driven twice in a step
	task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= rd;
		reg_wr <= !rd;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		#1;
		if (rd) chk(reg_rdata, d);
		@(posedge clk_sys);
	endtask : acc
	// Five edges cover pad, cell, output and chain stages
	task automatic pins_chk(input logic [5:0] w, input logic [2:0] e);
		want <= w;
		repeat (5) @(posedge clk_sys);
		#1;
		chk_out(ys, e);
		@(posedge clk_sys);
	endtask : pins_chk
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic t_reset;
		pins_chk(6'h3f, 3'h0);
		acc(1'b0, 8'h50, 8'hff);
		acc(1'b1, 8'h50, 8'h00);
		acc(1'b1, 8'h44, 8'h00);
		acc(1'b1, 8'h45, 8'h00);
	endtask : t_reset
	task automatic t_funcs;
		logic [7:0] f;
		logic [5:0] w;
		logic [2:0] e;
		for (int i = 0; i < 128; i++) begin
			f = 8'(i);
			w = 6'(i * 5 + 3);
			e = {cell_ref_pkg::exp_cell(f, w[5], w[4], w[3]),
				cell_ref_pkg::exp_cell(f, w[2], w[1], w[0]), 1'b0};
			if (f[2:0] != 3'h4) begin
				acc(1'b0, 8'h44, f | 8'h80);
				acc(1'b0, 8'h45, f);
				acc(1'b1, 8'h44, f);
				pins_chk(w, e);
			end
		end
	endtask : t_funcs
	task automatic t_chain;
		acc(1'b0, 8'h44, 8'h01);
		acc(1'b0, 8'h45, 8'h82);
		acc(1'b1, 8'h45, 8'h82);
		pins_chk(6'h1c, 3'h1);
		pins_chk(6'h38, 3'h7);
		acc(1'b0, 8'h45, 8'h02);
		pins_chk(6'h04, 3'h2);
	endtask : t_chain
	task automatic t_flop;
		acc(1'b0, 8'h44, 8'h04);
		acc(1'b0, 8'h45, 8'h04);
		acc(1'b0, 8'h46, 8'h05);
		acc(1'b1, 8'h46, 8'h05);
		pins_chk(6'h00, 3'h0);
		acc(1'b0, 8'h46, 8'h02);
		acc(1'b1, 8'h46, 8'h12);
		acc(1'b0, 8'h46, 8'h09);
		acc(1'b1, 8'h46, 8'h29);
		pins_chk(6'h00, 3'h2);
		acc(1'b0, 8'h46, 8'h03);
		acc(1'b0, 8'h46, 8'h00);
		acc(1'b1, 8'h46, 8'h30);
		pins_chk(6'h00, 3'h6);
		acc(1'b0, 8'h46, 8'h05);
		pins_chk(6'h20, 3'h0);
		pins_chk(6'h30, 3'h4);
	endtask : t_flop
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_funcs();
		t_chain();
		t_flop();
		report_and_stop();
	end
	// Tests need about 1460 cycles; the 10000-cycle limit allows nearly seven times that
	initial begin
		#250000;
		err_total++;
		report_and_stop();
	end
endmodule : dual_config_logic_cells_tb
